// ### src/ces_regs.vh
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit AXI4-Lite bus with byte addresses
`ifndef CES_REGS_VH
`define CES_REGS_VH
// Register byte offsets
`define CES_CTRL_OFS      8'h00
`define CES_STAT_OFS      8'h04
`define CES_DIFF_OFS      8'h08
`define CES_RATIO_OFS     8'h0c
`define CES_TRP_POS_OFS   8'h10
`define CES_TRP_NEG_OFS   8'h14
`define CES_SFT_POS_OFS   8'h18
`define CES_SFT_NEG_OFS   8'h1c
`define CES_SFT_ACT_OFS   8'h20
`define CES_ECHO_OFS      8'h24
`define CES_REF_OFS       8'h40
`define CES_BANK_OFS      8'h80
// Control fields
`define CES_TOPO_LSB      0
`define CES_X4_LSB        4
`define CES_FCLR_BIT      8
// Bank word fields
`define CES_ACT_LSB       28
// Reset values
`define CES_CTRL_RST      32'h0000_00f1
`define CES_RATIO_RST     24'h01_0000
`define CES_LIM_RST       16'h7fff
`define CES_LIMN_RST      16'h8001
`define CES_ACT_RST       2'h1
`define CES_REF_RST       16'h0100
// Difference saturation bound
`define CES_SAT_MAX       16'h7fff
// Timing
`define CES_CLK_MHZ       25
`define CES_SPEED_WIN_US  1000
`define CES_PCT_FULL      7'h64
// AXI responses
`define CES_RESP_OK       2'h0
`define CES_RESP_SLV      2'h2
`endif

// ### src/ces_supervisor.v
// Crane encoder supervisor: drum pulse difference and four-encoder overspeed
// Assumes raw encoder, clear, rescue and fault-reset pins; AXI4-Lite slave on clk_sys_i
`timescale 1ns/1ns
`include "ces_regs.vh"

// Overview of operation
// - Drum difference is drum-one count minus ratio-scaled drum-two count, topologies 1,4,5,6.
// - Reported drum difference saturates at plus or minus 32767.
// - Rising counter clear input zeroes drum counters and the difference.
// - Drum pulse counters are 32 bits wide.
// - Difference outside trip window opens the safety relays regardless of action.
// - Trip window has separate positive and negative limits; either one trips.
// - Separate positive and negative soft limits raise a soft deviation per action.
// - Action 1 opens both soft outputs, 2 only the first, 3 only second.
// - Configured trip and soft limits are readable as echo registers.
// - Leaving the trip window sets a latched drum difference trip fault.
// - Multiplier 4 counts all quadrature edges; 1 counts once per pulse.
// - Rescue mode input disables drum difference supervision entirely.
// - Absolute normalised speed of all four encoders is compared with levels.
// - Speed above trip level for its delay latches trip and opens relays.
// - Speed above soft level for its delay latches soft fault per action.
// - Motor levels are percent of motor synchronous speed.
// - Topology 1 drum full speed is both motors combined, else one motor.
// - Rescue mode input selects the alternate bank of levels, delays and actions.
// - Each encoder has own trip and soft levels, delays and action.
module ces_supervisor #(
  parameter        ADDR_W    = 8,
  parameter [15:0] WIN_CYC   = `CES_CLK_MHZ * `CES_SPEED_WIN_US
) (
  // Clock and reset
  input  wire              clk_sys_i,
  input  wire              rst_b_i,
  // AXI4-Lite write address and data
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  // AXI4-Lite read
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  // Encoder pins: motor one, motor two, drum one, drum two
  input  wire [3:0]        enc_a_i,
  input  wire [3:0]        enc_b_i,
  // Discrete inputs
  input  wire              counter_clear_input_i,
  input  wire              rescue_mode_input_i,
  input  wire              fault_reset_input_i,
  // Safety outputs, high means relay closed
  output wire              safety_relay_closed_o,
  output wire              soft_stop_output_a_o,
  output wire              soft_stop_output_b_o
);

  // Soft action decode for the first and second soft-stop output
  function act_a;
    input [1:0] code;
    act_a = (code == 2'h1) || (code == 2'h2);
  endfunction
  function act_b;
    input [1:0] code;
    act_b = (code == 2'h1) || (code == 2'h3);
  endfunction
  // Byte-lane merge of a write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = dat[k*8 +: 8];
    end
  endfunction

  // Configuration storage
  reg  [31:0] ctrl_q;
  reg  [23:0] ratio_q;
  reg  [15:0] trp_pos_q, trp_neg_q, sft_pos_q, sft_neg_q;
  reg  [1:0]  sft_act_q;
  reg  [15:0] ref_q  [0:3];
  reg  [31:0] bank_q [0:15];
  reg         sw_clr_q;
  // Bus handshake state
  reg         awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  reg  [1:0]  bresp_q, rresp_q;
  reg  [31:0] rdata_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  // Pin synchronisers; stage s1 only feeds s2
  reg  [3:0]  a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
  reg  [2:0]  cc_s, rs_s, fr_s;
  // Drum counters and difference
  reg  signed [31:0] d1_cnt_q, d2_cnt_q;
  reg  signed [15:0] diff_q;
  reg         drum_trip_q, drum_soft_q;
  // Speed window and outputs
  reg  [15:0] win_q;
  reg         tick_q;
  reg         relay_q, soa_q, sob_q;

  wire [2:0]  topo     = ctrl_q[`CES_TOPO_LSB +: 3];
  wire [3:0]  x4_sel   = ctrl_q[`CES_X4_LSB +: 4];
  wire        rescue   = rs_s[1];
  wire        cc_rise  = cc_s[1] & ~cc_s[2];
  wire        fclr     = sw_clr_q | fr_s[1];
  wire [3:0]  inc_w, dec_w, os_trip_w, os_soft_w, os_a_w, os_b_w;
  wire        wr_go    = ~awready_q & ~wready_q & ~bvalid_q;
  wire        aw_bank  = awaddr_q[7:6] == 2'h2;
  wire [3:0]  aw_bidx  = awaddr_q[5:2];
  wire        aw_refs  = awaddr_q[7:4] == 4'h4;

  // Synchronise every pin through two flops before use
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      a_s1 <= 4'h0; a_s2 <= 4'h0; a_s3 <= 4'h0;
      b_s1 <= 4'h0; b_s2 <= 4'h0; b_s3 <= 4'h0;
      cc_s <= 3'h0; rs_s <= 3'h0; fr_s <= 3'h0;
    end else begin
      a_s1 <= enc_a_i; a_s2 <= a_s1; a_s3 <= a_s2;
      b_s1 <= enc_b_i; b_s2 <= b_s1; b_s3 <= b_s2;
      cc_s <= {cc_s[1:0], counter_clear_input_i};
      rs_s <= {rs_s[1:0], rescue_mode_input_i};
      fr_s <= {fr_s[1:0], fault_reset_input_i};
    end
  end

  // Millisecond tick for speed measurement
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      win_q  <= 16'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (win_q == WIN_CYC - 16'h1);
      win_q  <= (win_q == WIN_CYC - 16'h1) ? 16'h0 : win_q + 16'h1;
    end
  end

  // Per-encoder decode, speed and overspeed timing
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_enc
      reg  signed [15:0] acc_q;
      reg  [15:0] spd_q;
      reg  [11:0] ttm_q, stm_q;
      reg         trip_q, soft_q;
      wire [31:0] w0    = bank_q[{rescue, i[1:0], 1'b0}];
      wire [31:0] w1    = bank_q[{rescue, i[1:0], 1'b1}];
      wire        ea    = a_s2[i] ^ a_s3[i];
      wire        eb    = b_s2[i] ^ b_s3[i];
      wire        fwd4  = (ea & (a_s2[i] ^ b_s2[i])) | (eb & ~(a_s2[i] ^ b_s2[i]));
      wire        up1   = a_s2[i] & ~a_s3[i];
      // Count all four edges or once per pulse on channel A rising
      assign inc_w[i] = x4_sel[i] ? (fwd4 & (ea | eb)) : (up1 & ~b_s2[i]);
      assign dec_w[i] = x4_sel[i] ? (~fwd4 & (ea | eb)) : (up1 & b_s2[i]);
      // Full-scale reference; differential drums are two motors combined
      wire [16:0] ref_e = (i >= 2 && topo == 3'h1) ? {ref_q[i], 1'b0} : {1'b0, ref_q[i]};
      wire [33:0] spd_s = spd_q * `CES_PCT_FULL;
      wire        ov_t  = spd_s > (w0[15:0] * ref_e);
      wire        ov_s  = spd_s > (w0[31:16] * ref_e);
      // Absolute pulse count per window is the speed
      always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          acc_q <= 16'sh0;
          spd_q <= 16'h0;
        end else if (tick_q) begin
          acc_q <= 16'sh0;
          spd_q <= acc_q[15] ? 16'h0 - acc_q : acc_q;
        end else if (inc_w[i]) begin
          acc_q <= acc_q + 16'sh1;
        end else if (dec_w[i]) begin
          acc_q <= acc_q - 16'sh1;
        end
      end
      // Delay timers restart below level; faults latch until reset
      always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          ttm_q  <= 12'h0;
          stm_q  <= 12'h0;
          trip_q <= 1'b0;
          soft_q <= 1'b0;
        end else begin
          if (tick_q)
            ttm_q <= !ov_t ? 12'h0 : (ttm_q >= w1[11:0]) ? ttm_q : ttm_q + 12'h1;
          if (tick_q)
            stm_q <= !ov_s ? 12'h0 : (stm_q >= w1[27:16]) ? stm_q : stm_q + 12'h1;
          // Set wins over a clear in the same cycle
          if (tick_q && ov_t && ttm_q >= w1[11:0])
            trip_q <= 1'b1;
          else if (fclr)
            trip_q <= 1'b0;
          if (tick_q && ov_s && stm_q >= w1[27:16])
            soft_q <= 1'b1;
          else if (fclr)
            soft_q <= 1'b0;
        end
      end
      assign os_trip_w[i] = trip_q;
      assign os_soft_w[i] = soft_q;
      assign os_a_w[i]    = soft_q & act_a(w1[`CES_ACT_LSB +: 2]);
      assign os_b_w[i]    = soft_q & act_b(w1[`CES_ACT_LSB +: 2]);
    end
  endgenerate

  // Drum difference with ratio scaling and saturation
  wire signed [56:0] d2_scl  = d2_cnt_q * $signed({1'b0, ratio_q});
  wire signed [41:0] dfull   = {{10{d1_cnt_q[31]}}, d1_cnt_q} - {d2_scl[56], d2_scl[56:16]};
  wire signed [41:0] sat_hi  = {26'h0, `CES_SAT_MAX};
  wire signed [41:0] sat_lo  = -sat_hi;
  wire [15:0]        dsat    = (dfull > sat_hi) ? `CES_SAT_MAX :
                               (dfull < sat_lo) ? 16'h0 - `CES_SAT_MAX : dfull[15:0];
  wire        topo_ok = (topo == 3'h1) || (topo == 3'h4) || (topo == 3'h5) || (topo == 3'h6);
  wire        sup_on  = topo_ok & ~rescue;
  wire        d_trip  = (diff_q > $signed(trp_pos_q)) || (diff_q < $signed(trp_neg_q));
  wire        d_soft  = (diff_q > $signed(sft_pos_q)) || (diff_q < $signed(sft_neg_q));

  // Drum counters clear on the counter clear rising edge
  always @(posedge clk_sys_i) begin
    if (!rst_b_i || cc_rise) begin
      d1_cnt_q <= 32'sh0;
      d2_cnt_q <= 32'sh0;
      diff_q   <= 16'sh0;
    end else begin
      d1_cnt_q <= d1_cnt_q + {{31{dec_w[2]}}, inc_w[2] | dec_w[2]};
      d2_cnt_q <= d2_cnt_q + {{31{dec_w[3]}}, inc_w[3] | dec_w[3]};
      diff_q   <= dsat;
    end
  end

  // Drum difference fault latches; set wins over clear
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      drum_trip_q <= 1'b0;
      drum_soft_q <= 1'b0;
    end else begin
      if (sup_on && d_trip)
        drum_trip_q <= 1'b1;
      else if (fclr)
        drum_trip_q <= 1'b0;
      if (sup_on && d_soft)
        drum_soft_q <= 1'b1;
      else if (fclr)
        drum_soft_q <= 1'b0;
    end
  end

  // Relay and soft-stop drive, high means closed
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      relay_q <= 1'b0;
      soa_q   <= 1'b0;
      sob_q   <= 1'b0;
    end else begin
      relay_q <= ~drum_trip_q & ~(|os_trip_w);
      soa_q   <= ~(drum_soft_q & act_a(sft_act_q)) & ~(|os_a_w);
      sob_q   <= ~(drum_soft_q & act_b(sft_act_q)) & ~(|os_b_w);
    end
  end

  // Byte-merged write values of the narrow registers, cut to width on use
  wire [31:0] m_ratio = merge({8'h0, ratio_q}, wdata_q, wstrb_q);
  wire [31:0] m_tpos  = merge({16'h0, trp_pos_q}, wdata_q, wstrb_q);
  wire [31:0] m_tneg  = merge({16'h0, trp_neg_q}, wdata_q, wstrb_q);
  wire [31:0] m_spos  = merge({16'h0, sft_pos_q}, wdata_q, wstrb_q);
  wire [31:0] m_sneg  = merge({16'h0, sft_neg_q}, wdata_q, wstrb_q);
  wire [31:0] m_ref   = merge({16'h0, ref_q[aw_bidx[1:0]]}, wdata_q, wstrb_q);

  // Write channel: take address and data in any order, then respond
  integer n;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CES_RESP_OK;
      awaddr_q  <= {ADDR_W{1'b0}};
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      sw_clr_q  <= 1'b0;
      ctrl_q    <= `CES_CTRL_RST;
      ratio_q   <= `CES_RATIO_RST;
      trp_pos_q <= `CES_LIM_RST;
      trp_neg_q <= `CES_LIMN_RST;
      sft_pos_q <= `CES_LIM_RST;
      sft_neg_q <= `CES_LIMN_RST;
      sft_act_q <= `CES_ACT_RST;
      for (n = 0; n < 4; n = n + 1)
        ref_q[n] <= `CES_REF_RST;
      for (n = 0; n < 16; n = n + 1)
        bank_q[n] <= 32'h0;
    end else begin
      sw_clr_q <= 1'b0;
      if (s_axi_awvalid_i && awready_q) begin
        awaddr_q  <= s_axi_awaddr_i;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
        wready_q <= 1'b0;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= `CES_RESP_OK;
        if (aw_bank)
          bank_q[aw_bidx] <= merge(bank_q[aw_bidx], wdata_q, wstrb_q);
        else if (aw_refs)
          ref_q[aw_bidx[1:0]] <= m_ref[15:0];
        else begin
          case (awaddr_q)
            `CES_CTRL_OFS: begin
              ctrl_q   <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_00f7;
              sw_clr_q <= wstrb_q[1] & wdata_q[`CES_FCLR_BIT];
            end
            `CES_RATIO_OFS:   ratio_q   <= m_ratio[23:0];
            `CES_TRP_POS_OFS: trp_pos_q <= m_tpos[15:0];
            `CES_TRP_NEG_OFS: trp_neg_q <= m_tneg[15:0];
            `CES_SFT_POS_OFS: sft_pos_q <= m_spos[15:0];
            `CES_SFT_NEG_OFS: sft_neg_q <= m_sneg[15:0];
            `CES_SFT_ACT_OFS: sft_act_q <= wstrb_q[0] ? wdata_q[1:0] : sft_act_q;
            `CES_STAT_OFS, `CES_DIFF_OFS: bresp_q <= `CES_RESP_OK;
            default:          bresp_q <= `CES_RESP_SLV;
          endcase
        end
      end
    end
  end

  // Read mux: state, difference and echoes of the limits
  reg [31:0] rd_d;
  reg        rd_err;
  always @* begin
    rd_d   = 32'h0;
    rd_err = 1'b0;
    if (s_axi_araddr_i[7:6] == 2'h2)
      rd_d = bank_q[s_axi_araddr_i[5:2]];
    else if (s_axi_araddr_i[7:4] == 4'h4)
      rd_d = {16'h0, ref_q[s_axi_araddr_i[3:2]]};
    else begin
      case (s_axi_araddr_i)
        `CES_CTRL_OFS:         rd_d = ctrl_q;
        `CES_STAT_OFS:         rd_d = {18'h0, sob_q, soa_q, relay_q, rescue, os_soft_w, os_trip_w,
                                       drum_soft_q, drum_trip_q};
        `CES_DIFF_OFS:         rd_d = {{16{diff_q[15]}}, diff_q};
        `CES_RATIO_OFS:        rd_d = {8'h0, ratio_q};
        `CES_TRP_POS_OFS,
        `CES_ECHO_OFS:         rd_d = {16'h0, trp_pos_q};
        `CES_TRP_NEG_OFS,
        `CES_ECHO_OFS + 8'h4:  rd_d = {16'h0, trp_neg_q};
        `CES_SFT_POS_OFS,
        `CES_ECHO_OFS + 8'h8:  rd_d = {16'h0, sft_pos_q};
        `CES_SFT_NEG_OFS,
        `CES_ECHO_OFS + 8'hc:  rd_d = {16'h0, sft_neg_q};
        `CES_SFT_ACT_OFS:      rd_d = {30'h0, sft_act_q};
        default:               rd_err = 1'b1;
      endcase
    end
  end

  // Read channel: one-cycle answer, held until taken
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `CES_RESP_OK;
    end else if (s_axi_arvalid_i && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_d;
      rresp_q   <= rd_err ? `CES_RESP_SLV : `CES_RESP_OK;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready_o       = awready_q;
  assign s_axi_wready_o        = wready_q;
  assign s_axi_bvalid_o        = bvalid_q;
  assign s_axi_bresp_o         = bresp_q;
  assign s_axi_arready_o       = arready_q;
  assign s_axi_rvalid_o        = rvalid_q;
  assign s_axi_rdata_o         = rdata_q;
  assign s_axi_rresp_o         = rresp_q;
  assign safety_relay_closed_o = relay_q;
  assign soft_stop_output_a_o  = soa_q;
  assign soft_stop_output_b_o  = sob_q;

endmodule // ces_supervisor

// ### tb/ces_enc_model.sv
// Four quadrature encoders turning one edge every DIV clocks while run is high
// Assumes run and dir come from the bench after clock edges; lines hold when stopped
`timescale 1ns/1ns
module ces_enc_model #(
  parameter DIV = 4
) (
  // Clock and motion controls
  input  wire       clk_i,
  input  wire [3:0] run_i,
  input  wire [3:0] dir_i,
  // Encoder lines
  output reg  [3:0] enc_a_o,
  output reg  [3:0] enc_b_o
);
  integer cnt [0:3];
  integer e;
  // Start standing still with both lines low
  initial begin
    enc_a_o = 4'h0;
    enc_b_o = 4'h0;
    for (e = 0; e < 4; e = e + 1) cnt[e] = 0;
  end
  // Gray step: A leads B when dir is high, B leads A otherwise
  always @(posedge clk_i) begin
    for (e = 0; e < 4; e = e + 1) begin
      if (!run_i[e]) begin
        cnt[e] <= 0;
      end else if (cnt[e] == DIV - 1) begin
        cnt[e] <= 0;
        if ((enc_a_o[e] == enc_b_o[e]) == dir_i[e]) enc_a_o[e] <= ~enc_a_o[e];
        else enc_b_o[e] <= ~enc_b_o[e];
      end else begin
        cnt[e] <= cnt[e] + 1;
      end
    end
  end
endmodule // ces_enc_model

// ### tb/ces_supervisor_chk.sv
// Checker: bus handshake timing and latched safety outputs of ces_supervisor
// Assumes it is bound to ces_supervisor and sees only its ports
`timescale 1ns/1ns
module ces_supervisor_chk (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_b_i,
  // Bus handshakes
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Fault reset and safety outputs
  input wire fault_reset_input_i,
  input wire safety_relay_closed_o,
  input wire soft_stop_output_a_o,
  input wire soft_stop_output_b_o
);
  // No fault clear by pin or by a control write is under way
  wire quiet = !fault_reset_input_i && !s_axi_wvalid_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_reset_state: assert property ($rose(rst_b_i) |-> !safety_relay_closed_o && s_axi_awready_o && !s_axi_bvalid_o)
    else $error("outputs wrong just after reset");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> !s_axi_awready_o && !s_axi_wready_o ##1 s_axi_bvalid_o) else $error("write not answered");
  a_write_close: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
    else $error("write response not closed");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered");
  a_read_close: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
    else $error("read response not closed");
  a_relay_latch: assert property (quiet [*5] ##0 $fell(safety_relay_closed_o) ##1 quiet [*3]
    |-> !safety_relay_closed_o) else $error("relay reclosed without fault reset");
  a_softa_latch: assert property (quiet [*5] ##0 $fell(soft_stop_output_a_o) ##1 quiet [*3]
    |-> !soft_stop_output_a_o) else $error("soft output a reclosed without fault reset");
  a_softb_latch: assert property (quiet [*5] ##0 $fell(soft_stop_output_b_o) ##1 quiet [*3]
    |-> !soft_stop_output_b_o) else $error("soft output b reclosed without fault reset");
endmodule // ces_supervisor_chk

// ### tb/crane_encoder_supervisor_bench.sv
// Bench: drum difference, overspeed, rescue bank and register bus of ces_supervisor
// Assumes the encoder model on the pins and the checker bound at the foot
`timescale 1ns/1ns
`include "ces_regs.vh"
module crane_encoder_supervisor_bench;
  localparam DV = 4;
  reg         clk_sys_i, rst_b_i, awvalid, wvalid, bready, arvalid, rready, clr_in, rescue, frst;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rd;
  reg  [1:0]  rr;
  reg  [3:0]  run, dir;
  wire        awready, wready, bvalid, arready, rvalid, relay, soft_a, soft_b;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  enc_a, enc_b;
  integer     mismatches, tests_run, i, act, dr, guard;
  // Device with a 50-cycle speed window
  ces_supervisor #(.WIN_CYC(16'd50)) i_ces_supervisor (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .enc_a_i(enc_a), .enc_b_i(enc_b), .counter_clear_input_i(clr_in),
    .rescue_mode_input_i(rescue), .fault_reset_input_i(frst), .safety_relay_closed_o(relay),
    .soft_stop_output_a_o(soft_a), .soft_stop_output_b_o(soft_b));
  // Encoders on the far side of the pins
  ces_enc_model #(.DIV(DV)) i_ces_enc_model (.clk_i(clk_sys_i), .run_i(run), .dir_i(dir),
    .enc_a_o(enc_a), .enc_b_o(enc_b));
  // 25 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // One bounded clock step; running out of steps ends the run
  task step;
    begin
      @(posedge clk_sys_i);
      guard = guard + 1;
      if (guard > 500) begin
        mismatches = mismatches + 1;
        test_done;
      end
    end
  endtask
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      guard = 0;
      do begin
        step;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", er, bresp);
      bready <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
  task axr(input [7:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      guard = 0;
      do begin
        step;
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge clk_sys_i);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      axr(a);
      chk("read data", e, rd);
    end
  endtask
  // Wait a bounded time for relay, soft a, soft b to reach the expected levels
  task outw(input [2:0] e);
    begin
      guard = 0;
      while ({relay, soft_a, soft_b} !== e) step;
      chk("outputs", e, {relay, soft_a, soft_b});
    end
  endtask
  // Turn the chosen encoders by k edges, then let the pins settle
  task mv(input [3:0] m, input [3:0] d, input integer k);
    begin
      run <= m;
      dir <= d;
      repeat (k * DV) @(posedge clk_sys_i);
      run <= 4'h0;
      repeat (8) @(posedge clk_sys_i);
    end
  endtask
  task pulse(input integer w);
    begin
      if (w) clr_in <= 1'b1;
      else frst <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      clr_in <= 1'b0;
      frst <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
    end
  endtask
  task lims(input [15:0] t, input [15:0] s);
    begin
      axw(`CES_TRP_POS_OFS, {16'h0, t}, `CES_RESP_OK);
      axw(`CES_TRP_NEG_OFS, {16'h0, 16'h0 - t}, `CES_RESP_OK);
      axw(`CES_SFT_POS_OFS, {16'h0, s}, `CES_RESP_OK);
      axw(`CES_SFT_NEG_OFS, {16'h0, 16'h0 - s}, `CES_RESP_OK);
    end
  endtask
  // Main sequence
  initial begin
    {rst_b_i, awvalid, wvalid, bready, arvalid, rready, clr_in, rescue, frst} = 9'h0;
    {awaddr, araddr, wdata, run, dir} = 56'h0;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(14502));
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc(`CES_CTRL_OFS, `CES_CTRL_RST);
    rdc(`CES_ECHO_OFS, 32'h0000_7fff);
    axr(8'h34);
    chk("unmapped rresp", `CES_RESP_SLV, rr);
    axw(`CES_ECHO_OFS, 32'h0, `CES_RESP_SLV);
    for (i = 0; i < 4; i = i + 1) begin
      axw(8'(`CES_REF_OFS + 4 * i), 32'h10, `CES_RESP_OK);
      axw(8'(`CES_BANK_OFS + 8 * i), 32'h03e8_03e8, `CES_RESP_OK);
      axw(8'(`CES_BANK_OFS + 8'h20 + 8 * i), 32'h03e8_03e8, `CES_RESP_OK);
    end
    lims(16'd40, 16'd20);
    axr(8'(`CES_ECHO_OFS + 4));
    chk("trip neg echo", 32'hffd8, {16'h0, rd[15:0]});
    // Drum difference: soft then trip on a random side with a random action
    for (i = 0; i < 4; i = i + 1) begin
      act = 1 + $urandom % 3;
      dr = $urandom % 2;
      axw(`CES_SFT_ACT_OFS, 32'(act), `CES_RESP_OK);
      mv(4'h4, {4{dr[0]}}, 25);
      outw({1'b1, act == 3, act == 2});
      rdc(`CES_DIFF_OFS, dr[0] ? 32'h19 : 32'hffff_ffe7);
      mv(4'h4, {4{dr[0]}}, 20);
      outw({1'b0, act == 3, act == 2});
      axr(`CES_STAT_OFS);
      chk("drum trip flag", 32'h1, {31'h0, rd[0]});
      pulse(1);
      rdc(`CES_DIFF_OFS, 32'h0);
      chk("relay held", 32'h0, {31'h0, relay});
      pulse(0);
      outw(3'b111);
    end
    // Single counting on drum one: two A rises in eight edges
    axw(`CES_CTRL_OFS, 32'h0000_00b1, `CES_RESP_OK);
    mv(4'h4, 4'hf, 8);
    rdc(`CES_DIFF_OFS, 32'h2);
    pulse(1);
    axw(`CES_CTRL_OFS, `CES_CTRL_RST, `CES_RESP_OK);
    // Large ratio drives the difference into saturation
    lims(16'h7fff, 16'h7fff);
    axw(`CES_RATIO_OFS, 32'h00ff_0000, `CES_RESP_OK);
    mv(4'h8, 4'hf, 200);
    rdc(`CES_DIFF_OFS, 32'hffff_8001);
    pulse(1);
    axw(`CES_RATIO_OFS, 32'h0001_0000, `CES_RESP_OK);
    // Overspeed per encoder: even ones trip, odd ones soft stop with action 2
    for (i = 0; i < 4; i = i + 1) begin
      axw(8'(`CES_BANK_OFS + 8 * i), i[0] ? 32'h001e_03e8 : 32'h03e8_001e, `CES_RESP_OK);
      axw(8'(`CES_BANK_OFS + 8 * i + 4), 32'h2000_0000, `CES_RESP_OK);
      mv(4'h1 << i, 4'hf, 300);
      outw(i[0] ? 3'b101 : 3'b011);
      axr(`CES_STAT_OFS);
      chk("overspeed flag", 32'h1, {31'h0, rd[i[0] ? 6 + i : 2 + i]});
      axw(8'(`CES_BANK_OFS + 8 * i), 32'h03e8_03e8, `CES_RESP_OK);
      pulse(1);
      // Odd encoders clear their faults through the control word instead of the pin
      if (i[0]) axw(`CES_CTRL_OFS, `CES_CTRL_RST | 32'h100, `CES_RESP_OK);
      else pulse(0);
      outw(3'b111);
    end
    // Rescue: drum supervision off and the alternate bank in use
    lims(16'd40, 16'd20);
    axw(8'(`CES_BANK_OFS + 8'h10), 32'h001e_001e, `CES_RESP_OK);
    rescue <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    mv(4'h4, 4'hf, 60);
    repeat (20) @(posedge clk_sys_i);
    chk("rescue outputs", 32'h7, {29'h0, relay, soft_a, soft_b});
    test_done;
  end
endmodule // crane_encoder_supervisor_bench
bind ces_supervisor ces_supervisor_chk i_ces_supervisor_chk (.clk_sys_i, .rst_b_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .fault_reset_input_i, .safety_relay_closed_o,
  .soft_stop_output_a_o, .soft_stop_output_b_o);
